// [bench/lpc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model
   import addr_decode_pkg::*;
(
   // Bus pins toward the target
   input wire logic mclk,
   output logic frame_n,
   output logic [NIB_W-1:0] lad_in
);
   // Idle bus sits high on its pull-ups
   initial begin
      frame_n = 1'b1;
      lad_in = 4'hf;
   end
   // Start cycle, start code, then n nibbles MSB first; n below 8 stops early, leaving lad_in at f and frame_n high
   task automatic send(input logic [ADDR_W-1:0] a, input int n);
      @(posedge mclk) frame_n <= 1'b0;
      lad_in <= START_CODE;
      @(posedge mclk) frame_n <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk) lad_in <= a[31-4*i -: 4];
      end
      @(posedge mclk) lad_in <= 4'hf;
   endtask : send
endmodule : lpc_host_model
`default_nettype wire

// [bench/lpc_target_address_decode_props.sv]
`timescale 1ns/1ps
`default_nettype none
module decode_props
   import addr_decode_pkg::*;
(
   // Watched ports
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic interface_reset_n,
   input wire logic cpu_reset_n,
   input wire logic frame_n,
   input wire logic array_sel,
   input wire logic reg_sel,
   input wire logic [OFS_W-1:0] array_offset,
   input wire logic [BLK_W-1:0] block_index,
   input wire logic claim,
   input wire logic aamux_mode,
   input wire logic read_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire logic pins_up = interface_reset_n && cpu_reset_n;
   // Pin resets high long enough to pass the sync flops
   sequence pins_quiet;
      pins_up [*4];
   endsequence
   claim_is_or_a:
      assert property (claim == (array_sel | reg_sel)) else $error("claim not the strobe or");
   sel_onehot_a:
      assert property (!(array_sel && reg_sel)) else $error("both strobes high");
   strobe_pulse_a:
      assert property (claim |=> !claim) else $error("strobe longer than one cycle");
   block_field_a:
      assert property (claim |-> block_index == array_offset[BLK_HI:BLK_LO]) else $error("block");
   offset_hold_a:
      assert property (disable iff (!rst_n || !pins_up) $changed(array_offset) |-> claim)
         else $error("offset moved without claim");
   read_mode_a:
      assert property (read_mode) else $error("not in read mode");
   mux_silent_a:
      assert property (aamux_mode |-> !claim) else $error("claim in mux mode");
   frame_high_a:
      assert property (claim |-> $past(frame_n, 5)) else $error("claim after frame low");
   select_latch_a:
      assert property (pins_quiet |=> $stable(aamux_mode)) else $error("mode changed");
endmodule : decode_props
bind lpc_target_address_decode decode_props u_decode_props (.mclk, .rst_n,
   .interface_reset_n, .cpu_reset_n, .frame_n, .array_sel, .reg_sel, .array_offset,
   .block_index, .claim, .aamux_mode, .read_mode);
`default_nettype wire

// [bench/tb_lpc_target_address_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_lpc_target_address_decode;
   import addr_decode_pkg::*;
   logic mclk, rst_n, interface_reset_n, cpu_reset_n, interface_select, frame_n;
   logic array_sel, reg_sel, claim, aamux_mode, read_mode;
   logic [NIB_W-1:0] lad_in;
   logic [STRAP_W-1:0] chip_id_strap;
   logic [OFS_W-1:0] array_offset;
   logic [BLK_W-1:0] block_index;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   lpc_target_address_decode u_lpc_target_address_decode (.mclk, .rst_n, .interface_reset_n,
      .cpu_reset_n, .frame_n, .lad_in, .chip_id_strap, .interface_select, .array_sel,
      .reg_sel, .array_offset, .block_index, .claim, .aamux_mode, .read_mode);
   lpc_host_model u_lpc_host_model (.mclk, .frame_n, .lad_in);
   // 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Full address cycle; strobes caught at negedge so the pulse has settled
   task automatic go(input logic [31:0] a, input logic [1:0] exp);
      logic [1:0] seen;
      seen = 2'b00;
      u_lpc_host_model.send(a, 8);
      repeat (8) begin
         @(negedge mclk);
         if (claim !== 1'b0) seen = {array_sel, reg_sel};
      end
      check("strobes", {30'h0, exp}, {30'h0, seen});
      if (exp != 2'b00) check("offset", {13'h0, a[18:0]}, {13'h0, array_offset});
      if (exp != 2'b00) check("block", {29'h0, a[18:16]}, {29'h0, block_index});
   endtask : go
   task automatic t_windows();
      go({8'hff, 1'b1, 4'hc, 19'h5a5a5}, 2'b10);
      go({8'hff, 1'b0, 4'hc, 19'h00001}, 2'b01);
      go({8'h00, 1'b0, 4'h2, 19'h7ffff}, 2'b10);
      go({8'h00, 1'b1, 4'h2, 19'h10000}, 2'b01);
      go({8'hfe, 1'b1, 4'hc, 19'h00000}, 2'b00);
      go({8'h01, 1'b0, 4'h2, 19'h00000}, 2'b00);
      go({8'hff, 1'b1, 4'h3, 19'h00000}, 2'b00);
      u_lpc_host_model.send(32'hffe00000, 4);
      go({8'hff, 1'b0, 4'hc, 19'h23456}, 2'b01);
      $display("windows done");
   endtask : t_windows
   task automatic t_straps();
      for (int s = 0; s < 16; s++) begin
         @(posedge mclk) chip_id_strap <= 4'(s);
         repeat (4) @(posedge mclk);
         go({8'hff, 1'b1, ~4'(s), 19'h4 + 19'(s)}, 2'b10);
         go({8'h00, 1'b0, 4'(s) ^ 4'h1, 19'h0}, 2'b10);
      end
      $display("straps done");
   endtask : t_straps
   task automatic t_latch();
      @(posedge mclk) interface_select <= 1'b1;
      cpu_reset_n <= 1'b0;
      repeat (5) @(posedge mclk);
      cpu_reset_n <= 1'b1;
      repeat (5) @(posedge mclk);
      check("aamux", 32'h1, {31'h0, aamux_mode});
      go({8'hff, 1'b1, 4'h0, 19'h0}, 2'b00);
      @(posedge mclk) interface_select <= 1'b0;
      go({8'hff, 1'b1, 4'h0, 19'h0}, 2'b00);
      @(posedge mclk) interface_reset_n <= 1'b0;
      repeat (5) @(posedge mclk);
      interface_reset_n <= 1'b1;
      repeat (5) @(posedge mclk);
      check("cleared", 32'h00100000, {11'h0, read_mode, array_offset, aamux_mode});
      go({8'hff, 1'b1, 4'h0, 19'h1}, 2'b10);
      $display("latch done");
   endtask : t_latch
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   // Hang guard well above the run length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         summarize();
      end
   end
   // Reset, then the scenarios
   initial begin
      rst_n = 1'b0;
      interface_reset_n = 1'b0;
      cpu_reset_n = 1'b0;
      interface_select = 1'b0;
      chip_id_strap = 4'h3;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      interface_reset_n <= 1'b1;
      cpu_reset_n <= 1'b1;
      repeat (6) @(posedge mclk);
      t_windows();
      t_straps();
      t_latch();
      summarize();
   end
endmodule : tb_lpc_target_address_decode
`default_nettype wire

// [hw/id_match.sv]
`timescale 1ns/1ps
`default_nettype none
// Expected A22..A19 coding for a strap value, both windows
module id_match
   import addr_decode_pkg::*;
(
   // Strap and address field
   input wire logic [STRAP_W-1:0] strap,
   input wire logic [STRAP_W-1:0] addr_id,
   input wire logic top_window,
   // Result
   output logic match
);
   logic [STRAP_W-1:0] expect_top;
   logic [STRAP_W-1:0] expect_bottom;

   // Top coding is the strap inverted; bottom flips bit 0 only
   always_comb begin
      expect_top = ~strap;
      expect_bottom = strap ^ 4'h1;
      match = (addr_id == (top_window ? expect_top : expect_bottom));
   end
endmodule : id_match
`default_nettype wire

// [hw/lpc_target_address_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module lpc_target_address_decode
   import addr_decode_pkg::*;
(
   // Clock and resets
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic interface_reset_n,
   input wire logic cpu_reset_n,
   // Bus pins
   input wire logic frame_n,
   input wire logic [NIB_W-1:0] lad_in,
   // Straps
   input wire logic [STRAP_W-1:0] chip_id_strap,
   input wire logic interface_select,
   // Decode results
   output logic array_sel,
   output logic reg_sel,
   output logic [OFS_W-1:0] array_offset,
   output logic [BLK_W-1:0] block_index,
   output logic claim,
   output logic aamux_mode,
   output logic read_mode
);
   // Pin synchronisers, first stage read only by second
   logic [NIB_W+STRAP_W+3:0] sync1_reg, sync2_reg;
   logic frame_s, ires_s, cres_s, isel_s;
   logic [NIB_W-1:0] lad_s;
   logic [STRAP_W-1:0] strap_s;
   logic int_rst_n;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {frame_n, interface_reset_n, cpu_reset_n, interface_select,
                       lad_in, chip_id_strap};
         sync2_reg <= sync1_reg;
      end
   end

   // Split the synchronised word
   always_comb begin
      {frame_s, ires_s, cres_s, isel_s, lad_s, strap_s} = sync2_reg;
      int_rst_n = rst_n && ires_s && cres_s;
   end

   // Interface select latched while reset holds, frozen after
   logic isel_reg, isel_next;
   always_comb begin
      isel_next = isel_reg;
      if (!(ires_s && cres_s)) begin
         isel_next = isel_s;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         isel_reg <= 1'b0;
      end else begin
         isel_reg <= isel_next;
      end
   end

   // Address collection: start nibble then eight address nibbles
   collect_state_t state_reg, state_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [3:0] cnt_reg, cnt_next;
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (!frame_s && !isel_reg) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            // Frame held low restarts; release with start code begins address
            if (frame_s) begin
               if (lad_s == START_CODE) begin
                  state_next = ST_ADDR;
                  addr_next = {addr_reg[ADDR_W-NIB_W-1:0], lad_s};
                  cnt_next = 4'h1;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_ADDR: begin
            if (!frame_s) begin
               state_next = ST_START;
            end else begin
               addr_next = {addr_reg[ADDR_W-NIB_W-1:0], lad_s};
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == ADDR_NIBBLES) begin
                  state_next = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            state_next = frame_s ? ST_IDLE : ST_START;
         end
      endcase
   end
   always_ff @(posedge mclk) begin
      if (!int_rst_n) begin
         state_reg <= ST_IDLE;
         addr_reg <= ADDR_RST;
         cnt_reg <= CNT_RST;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         cnt_reg <= cnt_next;
      end
   end

   // Window and identity decode of the collected address
   logic top_win, bot_win, id_ok;
   id_match u_id_match (
      .strap(strap_s),
      .addr_id(addr_reg[ID_HI:ID_LO]),
      .top_window(top_win),
      .match(id_ok)
   );

   logic asel_next, rsel_next, claim_next;
   logic [OFS_W-1:0] ofs_next;
   logic [BLK_W-1:0] blk_next;
   always_comb begin
      top_win = (addr_reg[WIN_HI:WIN_LO] == WIN_TOP);
      bot_win = (addr_reg[WIN_HI:WIN_LO] == WIN_BOTTOM);
      // Strobes pulse only once, the cycle after the last nibble lands
      claim_next = (state_reg == ST_DONE) && frame_s && (top_win || bot_win)
                   && id_ok;
      asel_next = claim_next && (top_win ? addr_reg[SPACE_BIT]
                                         : !addr_reg[SPACE_BIT]);
      rsel_next = claim_next && !asel_next;
      ofs_next = claim_next ? addr_reg[OFS_W-1:0] : array_offset;
      blk_next = claim_next ? addr_reg[BLK_HI:BLK_LO] : block_index;
   end

   // Output flops; reset returns to read mode with no selection
   always_ff @(posedge mclk) begin
      if (!int_rst_n) begin
         array_sel <= 1'b0;
         reg_sel <= 1'b0;
         claim <= 1'b0;
         array_offset <= OFS_RST;
         block_index <= BLK_RST;
         read_mode <= 1'b1;
      end else begin
         array_sel <= asel_next;
         reg_sel <= rsel_next;
         claim <= claim_next;
         array_offset <= ofs_next;
         block_index <= blk_next;
         read_mode <= 1'b1;
      end
   end

   // Mode flag mirrors the latched select
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         aamux_mode <= 1'b0;
      end else begin
         aamux_mode <= isel_reg;
      end
   end
endmodule : lpc_target_address_decode
`default_nettype wire

// [inc/addr_decode_pkg.sv]
package addr_decode_pkg;
   // Address word and window layout
   localparam int ADDR_W = 32;
   localparam int WIN_HI = 31;
   localparam int WIN_LO = 24;
   localparam int SPACE_BIT = 23;
   localparam int ID_HI = 22;
   localparam int ID_LO = 19;
   localparam int OFS_W = 19;
   localparam int BLK_HI = 18;
   localparam int BLK_LO = 16;
   localparam int BLK_W = 3;
   localparam int STRAP_W = 4;
   localparam logic [7:0] WIN_TOP = 8'hff;
   localparam logic [7:0] WIN_BOTTOM = 8'h00;
   // Four address bits per nibble, eight nibbles per address cycle
   localparam int NIB_W = 4;
   localparam logic [3:0] ADDR_NIBBLES = 4'h8;
   localparam logic [3:0] START_CODE = 4'h0;
   // Reset values
   localparam logic [OFS_W-1:0] OFS_RST = 19'h00000;
   localparam logic [BLK_W-1:0] BLK_RST = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
   localparam logic [3:0] CNT_RST = 4'h0;

   // Address collection states, Gray coded along the usual path
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_ADDR = 2'b11,
      ST_DONE = 2'b10
   } collect_state_t;
endpackage : addr_decode_pkg
